// >>> src/rtccs_pkg.sv
// Constants, register map and types for the clock control and status block.
// Assumes a 10 MHz system clock and the oscillator time base sampled as a pin.
package rtccs_pkg;

	// ----------------------------------------------------------------
	// Register offsets
	// ----------------------------------------------------------------
	localparam logic [5:0] DIVIDER_RATE_CONTROL_OFS  = 6'h0a;
	localparam logic [5:0] RTC_MODE_CONTROL_OFS      = 6'h0b;
	localparam logic [5:0] INTERRUPT_FLAG_STATUS_OFS = 6'h0c;
	localparam logic [5:0] RAM_TIME_VALID_STATUS_OFS = 6'h0d;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int UPDATE_PENDING_BIT = 7;
	localparam int DIV_SEL_LSB        = 4;
	localparam int RATE_SEL_LSB       = 0;
	localparam int SET_HOLD_BIT       = 7;
	localparam int PIE_BIT            = 6;
	localparam int AIE_BIT            = 5;
	localparam int UIE_BIT            = 4;
	localparam int SQUARE_OUT_ENABLE_BIT           = 3;
	localparam int BINARY_FMT_BIT     = 2;
	localparam int HOUR24_BIT         = 1;
	localparam int SUMMER_BIT         = 0;
	localparam int IRQ_SUMMARY_FLAG_BIT           = 7;
	localparam int PF_BIT             = 6;
	localparam int AF_BIT             = 5;
	localparam int UF_BIT             = 4;
	localparam int VRT_BIT            = 7;

	// ----------------------------------------------------------------
	// Reset values (system reset only; the reset pin spares these)
	// ----------------------------------------------------------------
	localparam logic [2:0] DIV_SEL_RST  = 3'h0;
	localparam logic [3:0] RATE_SEL_RST = 4'h0;
	localparam logic [7:0] MODE_RST     = 8'h00;

	// ----------------------------------------------------------------
	// Divider chain
	// ----------------------------------------------------------------
	localparam int         DIV_STAGES   = 22;
	localparam logic [2:0] DIV_SEL_4M   = 3'h0;
	localparam logic [2:0] DIV_SEL_1M   = 3'h1;
	localparam logic [1:0] DIV_RST_CODE = 2'h3;
	localparam logic [21:0] SEC_MASK_4M  = 22'h3fffff;
	localparam logic [21:0] SEC_MASK_1M  = 22'h0fffff;
	localparam logic [21:0] SEC_MASK_32K = 22'h007fff;
	localparam int         TAP_BASE     = 6;
	localparam longint     FREQ_4M_HZ   = 4194304;
	localparam longint     FREQ_1M_HZ   = 1048576;
	localparam longint     FREQ_32K_HZ  = 32768;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam longint T_BUC_NS     = 244000;
	localparam longint T_UC_FAST_NS = 248000;
	localparam longint T_UC_SLOW_NS = 1984000;
	localparam longint CLK_NS       = 100;
	localparam longint NS_PER_S     = 1000000000;
	localparam logic [21:0] LEAD_4M  = 22'((T_BUC_NS * FREQ_4M_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam logic [21:0] LEAD_1M  = 22'((T_BUC_NS * FREQ_1M_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam logic [21:0] LEAD_32K = 22'((T_BUC_NS * FREQ_32K_HZ + NS_PER_S - 1) / NS_PER_S);
	localparam int UC_FAST_CYC = int'(T_UC_FAST_NS / CLK_NS);
	localparam int UC_SLOW_CYC = int'(T_UC_SLOW_NS / CLK_NS);

	typedef enum logic {UPD_IDLE, UPD_RUN} rtccs_upd_type;

endpackage : rtccs_pkg

// >>> src/rtccs_regs.sv
// Control and status registers of a real-time clock: update timing, divider,
// periodic tap, square wave, interrupt flags and the validity indicator.
// Assumes the calendar datapath runs on clk_sys and feeds the time bytes.
`timescale 1ns/1ns
module rtccs_regs
	import rtccs_pkg::*;
#(
	parameter int UC_SLOW_CYCLES = rtccs_pkg::UC_SLOW_CYC
) (
	input  wire logic       clk_sys,
	input  wire logic       sys_rst,
	input  wire logic       reset_in_n,
	input  wire logic       power_sense_in,
	input  wire logic       time_base_in,
	input  wire logic       addr_strobe_in,
	input  wire logic       data_strobe_in,
	input  wire logic       read_write_in,
	input  wire logic       chip_enable_n_in,
	input  wire logic [7:0] ad_in,
	output logic      [7:0] ad_out,
	output logic            ad_oe,
	output logic            irq_n_out,
	output logic            irq_oe,
	output logic            square_wave_out,
	input  wire logic [7:0] time_seconds,
	input  wire logic [7:0] time_minutes,
	input  wire logic [7:0] time_hours,
	input  wire logic [7:0] alarm_seconds,
	input  wire logic [7:0] alarm_minutes,
	input  wire logic [7:0] alarm_hours,
	output logic            update_advance,
	output logic            binary_format_select,
	output logic            hour24_select,
	output logic            summer_time_enable
);
	import rtccs_pkg::*;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic [13:0] pin_s1_reg;
	logic [13:0] pin_s2_reg;
	logic        as_prev_reg;
	logic        ds_prev_reg;
	logic        tb_prev_reg;
	logic        rst_pin_low;
	logic        ps_s;
	logic        tb_s;
	logic        as_s;
	logic        ds_s;
	logic        rw_s;
	logic        ce_n_s;
	logic [7:0]  ad_s;
	logic        rst_pin_s1_reg;
	logic        rst_pin_s_reg;

	// Two flops on every pin; only the second stage is read
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pin_s1_reg <= 14'h0001;
			pin_s2_reg <= 14'h0001;
		end else begin
			pin_s1_reg <= {ad_in, chip_enable_n_in, read_write_in, data_strobe_in,
				addr_strobe_in, time_base_in, power_sense_in};
			pin_s2_reg <= pin_s1_reg;
		end
	end

	assign ps_s        = pin_s2_reg[0];
	assign tb_s        = pin_s2_reg[1];
	assign as_s        = pin_s2_reg[2];
	assign ds_s        = pin_s2_reg[3];
	assign rw_s        = pin_s2_reg[4];
	assign ce_n_s      = pin_s2_reg[5];
	assign ad_s        = pin_s2_reg[13:6];
	assign rst_pin_low = ~rst_pin_s_reg; // Second flop of the reset pin only

	// Reset pin passes its own pair of flops, idle high
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rst_pin_s1_reg <= 1'b1;
			rst_pin_s_reg  <= 1'b1;
		end else begin
			rst_pin_s1_reg <= reset_in_n;
			rst_pin_s_reg  <= rst_pin_s1_reg;
		end
	end

	// Edge history of the synchronised strobes and time base
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			as_prev_reg <= 1'b0;
			ds_prev_reg <= 1'b0;
			tb_prev_reg <= 1'b0;
		end else begin
			as_prev_reg <= as_s;
			ds_prev_reg <= ds_s;
			tb_prev_reg <= tb_s;
		end
	end

	// ----------------------------------------------------------------
	// Multiplexed bus
	// ----------------------------------------------------------------
	logic [5:0] addr_reg;
	logic       as_fall;
	logic       ds_rise;
	logic       ds_fall;
	logic       wr_done;
	logic       rd_start;
	logic       rd_done;

	assign as_fall  = as_prev_reg & ~as_s & ~ce_n_s;
	assign ds_rise  = ~ds_prev_reg & ds_s & ~ce_n_s;
	assign ds_fall  = ds_prev_reg & ~ds_s & ~ce_n_s;
	assign wr_done  = ds_fall & ~rw_s;
	assign rd_start = ds_rise & rw_s;
	assign rd_done  = ds_fall & rw_s;

	// Address is taken at the falling address strobe, low six lines only
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			addr_reg <= 6'h00;
		end else if (as_fall) begin
			addr_reg <= ad_s[5:0];
		end
	end

	// ----------------------------------------------------------------
	// Software-owned control bits
	// ----------------------------------------------------------------
	logic [2:0] div_sel_reg;
	logic [3:0] rate_sel_reg;
	logic       set_hold_reg;
	logic       binary_reg;
	logic       hour24_reg;
	logic       summer_reg;
	logic       wr_a;
	logic       wr_b;

	assign wr_a = wr_done && addr_reg == DIVIDER_RATE_CONTROL_OFS;
	assign wr_b = wr_done && addr_reg == RTC_MODE_CONTROL_OFS;

	// Only system reset touches these; the reset pin spares them
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_sel_reg  <= DIV_SEL_RST;
			rate_sel_reg <= RATE_SEL_RST;
		end else if (wr_a) begin
			div_sel_reg  <= ad_s[DIV_SEL_LSB +: 3];
			rate_sel_reg <= ad_s[RATE_SEL_LSB +: 4];
		end
	end

	// Set-hold and format bits move only on a software write
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			set_hold_reg <= MODE_RST[SET_HOLD_BIT];
			binary_reg   <= MODE_RST[BINARY_FMT_BIT];
			hour24_reg   <= MODE_RST[HOUR24_BIT];
			summer_reg   <= MODE_RST[SUMMER_BIT];
		end else if (wr_b) begin
			set_hold_reg <= ad_s[SET_HOLD_BIT];
			binary_reg   <= ad_s[BINARY_FMT_BIT];
			hour24_reg   <= ad_s[HOUR24_BIT];
			summer_reg   <= ad_s[SUMMER_BIT];
		end
	end

	// Formats steer the calendar datapath, which does the special hours
	assign binary_format_select = binary_reg;
	assign hour24_select        = hour24_reg;
	assign summer_time_enable   = summer_reg;

	// Enables: the reset pin clears them, a set-hold write drops update-end
	logic pie_reg;
	logic aie_reg;
	logic uie_reg;
	logic square_out_enable_reg;
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pie_reg  <= 1'b0;
			aie_reg  <= 1'b0;
			uie_reg  <= 1'b0;
			square_out_enable_reg <= 1'b0;
		end else if (rst_pin_low) begin
			pie_reg  <= 1'b0;
			aie_reg  <= 1'b0;
			uie_reg  <= 1'b0;
			square_out_enable_reg <= 1'b0;
		end else if (wr_b) begin
			pie_reg  <= ad_s[PIE_BIT];
			aie_reg  <= ad_s[AIE_BIT];
			uie_reg  <= ad_s[UIE_BIT] & ~ad_s[SET_HOLD_BIT];
			square_out_enable_reg <= ad_s[SQUARE_OUT_ENABLE_BIT];
		end
	end

	// ----------------------------------------------------------------
	// Divider chain and second boundary
	// ----------------------------------------------------------------
	logic [21:0] div_reg;
	logic [21:0] sec_mask;
	logic [21:0] lead;
	logic        div_held;
	logic        tb_tick;
	logic        sec_tick;
	logic        near_end;

	assign div_held = div_sel_reg[2:1] == DIV_RST_CODE;
	assign tb_tick  = tb_s & ~tb_prev_reg;

	// Chain length sets one second per time base
	always_comb begin
		if (div_sel_reg == DIV_SEL_4M) begin
			sec_mask = SEC_MASK_4M;
			lead     = LEAD_4M;
		end else if (div_sel_reg == DIV_SEL_1M) begin
			sec_mask = SEC_MASK_1M;
			lead     = LEAD_1M;
		end else begin
			sec_mask = SEC_MASK_32K;
			lead     = LEAD_32K;
		end
	end

	assign sec_tick = tb_tick & ~div_held & ((div_reg & sec_mask) == sec_mask);
	// Pending shows ahead of the boundary so a reader never races it
	assign near_end = ~div_held & ((div_reg & sec_mask) >= sec_mask - lead + 22'h000001);

	// Held at zero while in reset, so the first second is a whole one
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			div_reg <= 22'h000000;
		end else if (div_held) begin
			div_reg <= 22'h000000;
		end else if (tb_tick) begin
			div_reg <= (div_reg + 22'h000001) & sec_mask;
		end
	end

	// ----------------------------------------------------------------
	// Update cycle
	// ----------------------------------------------------------------
	rtccs_upd_type upd_reg;
	logic [15:0]   upd_cnt_reg;
	logic [15:0]   upd_len;
	logic          upd_done;
	logic          update_pending_flag;

	assign upd_len  = (div_sel_reg == DIV_SEL_4M || div_sel_reg == DIV_SEL_1M) ?
		16'(UC_FAST_CYC) : 16'(UC_SLOW_CYCLES);
	assign upd_done = upd_reg == UPD_RUN && !set_hold_reg && upd_cnt_reg == upd_len - 16'h0001;
	assign update_advance = upd_done;
	// Set-hold masks both the lead-in and the update itself
	assign update_pending_flag = ~set_hold_reg & (near_end | upd_reg == UPD_RUN);

	// Once per second an update runs; set-hold aborts it at once
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			upd_reg     <= UPD_IDLE;
			upd_cnt_reg <= 16'h0000;
		end else begin
			case (upd_reg)
				UPD_IDLE: begin
					upd_cnt_reg <= 16'h0000;
					if (sec_tick && !set_hold_reg) begin
						upd_reg <= UPD_RUN;
					end
				end
				UPD_RUN: begin
					upd_cnt_reg <= upd_cnt_reg + 16'h0001;
					if (set_hold_reg || upd_done) begin
						upd_reg <= UPD_IDLE;
					end
				end
				default: upd_reg <= UPD_IDLE;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Periodic tap and square wave
	// ----------------------------------------------------------------
	logic tap;
	logic tap_prev_reg;
	logic tap_rise;
	logic sqw_reg;

	// Code zero disables; codes 1..15 pick one stage each
	assign tap      = (rate_sel_reg != 4'h0) && div_reg[TAP_BASE + int'(rate_sel_reg)];
	assign tap_rise = tap & ~tap_prev_reg;

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			tap_prev_reg <= 1'b0;
			sqw_reg      <= 1'b0;
		end else begin
			tap_prev_reg <= tap;
			sqw_reg      <= square_out_enable_reg & tap;
		end
	end
	assign square_wave_out = sqw_reg;

	// ----------------------------------------------------------------
	// Interrupt flags
	// ----------------------------------------------------------------
	logic pf_reg;
	logic af_reg;
	logic uf_reg;
	logic irq_summary_flag;
	logic rd_c;
	logic alarm_hit;

	assign rd_c = rd_done && addr_reg == INTERRUPT_FLAG_STATUS_OFS;
	// Top two bits set make an alarm byte a wildcard
	assign alarm_hit = (alarm_seconds[7:6] == 2'h3 || alarm_seconds == time_seconds) &&
		(alarm_minutes[7:6] == 2'h3 || alarm_minutes == time_minutes) &&
		(alarm_hours[7:6] == 2'h3 || alarm_hours == time_hours);

	// An event in the clearing read's cycle survives; the reset pin wins over all
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			pf_reg <= 1'b0;
			af_reg <= 1'b0;
			uf_reg <= 1'b0;
		end else if (rst_pin_low) begin
			pf_reg <= 1'b0;
			af_reg <= 1'b0;
			uf_reg <= 1'b0;
		end else begin
			pf_reg <= tap_rise | (pf_reg & ~rd_c);
			af_reg <= (upd_done & alarm_hit) | (af_reg & ~rd_c);
			uf_reg <= upd_done | (uf_reg & ~rd_c);
		end
	end

	assign irq_summary_flag = (pf_reg & pie_reg) | (af_reg & aie_reg) | (uf_reg & uie_reg);
	// Open drain: drive low only while the summary flag stands
	assign irq_n_out = 1'b0;
	assign irq_oe    = irq_summary_flag;

	// ----------------------------------------------------------------
	// Validity bit and read data
	// ----------------------------------------------------------------
	logic vrt_reg;
	logic [7:0] rdata_reg;

	// Power sense low forces zero; a read of its register sets it
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			vrt_reg <= 1'b0;
		end else if (!ps_s) begin
			vrt_reg <= 1'b0;
		end else if (rd_done && addr_reg == RAM_TIME_VALID_STATUS_OFS) begin
			vrt_reg <= 1'b1;
		end
	end

	// Read value is captured at the rising data strobe and held
	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			rdata_reg <= 8'h00;
		end else if (rd_start) begin
			if (addr_reg == DIVIDER_RATE_CONTROL_OFS) begin
				rdata_reg <= {update_pending_flag, div_sel_reg, rate_sel_reg};
			end else if (addr_reg == RTC_MODE_CONTROL_OFS) begin
				rdata_reg <= {set_hold_reg, pie_reg, aie_reg, uie_reg,
					square_out_enable_reg, binary_reg, hour24_reg, summer_reg};
			end else if (addr_reg == INTERRUPT_FLAG_STATUS_OFS) begin
				rdata_reg <= {irq_summary_flag, pf_reg, af_reg, uf_reg, 4'h0};
			end else if (addr_reg == RAM_TIME_VALID_STATUS_OFS) begin
				rdata_reg <= {vrt_reg, 7'h00};
			end else begin
				rdata_reg <= 8'h00;
			end
		end
	end
	assign ad_out = rdata_reg;
	assign ad_oe  = ds_s & rw_s & ~ce_n_s;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	sequence s_set_write;
		wr_b && ad_s[SET_HOLD_BIT];
	endsequence

	a_irq_pin_flags: assert property (irq_oe == (|{pf_reg & pie_reg, af_reg & aie_reg,
		uf_reg & uie_reg})) else $error("irq pin disagrees with flags");
	a_set_clears_uip: assert property (s_set_write |=> !update_pending_flag ##1
		upd_reg == UPD_IDLE) else $error("update flag not cleared by set-hold");
	a_set_drops_uie: assert property (s_set_write |=> !uie_reg)
		else $error("update-end enable survived set-hold");
	a_update_end_flag: assert property (upd_done && !rst_pin_low |=> uf_reg)
		else $error("update end did not set flag");
	a_periodic_flag: assert property (tap_rise && !rst_pin_low |=> pf_reg)
		else $error("periodic flag not set on tap");
	a_read_clears: assert property (rd_c && !tap_rise && !upd_done |=> !pf_reg && !uf_reg)
		else $error("status read did not clear flags");
	a_square_low: assert property (!square_out_enable_reg |=> !square_wave_out)
		else $error("square output not held low");
	a_vrt_power: assert property (!ps_s |=> !vrt_reg ##1 !ps_s |-> !vrt_reg)
		else $error("valid bit set while power sense low");
	a_selects_keep: assert property (rst_pin_low && !wr_a |=> $stable(div_sel_reg) &&
		$stable(rate_sel_reg)) else $error("selects changed by reset pin");
	a_update_start: assert property (sec_tick && !set_hold_reg && upd_reg == UPD_IDLE
		|=> upd_reg == UPD_RUN) else $error("second boundary started no update");

endmodule : rtccs_regs

// >>> tb/rtccs_cpu_model.sv
// Processor model for the clock block's multiplexed address/data bus.
// Assumes the bench clock; pins change only on its falling edge.
`timescale 1ns/1ns
module rtccs_cpu_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] ad_out,
	input  wire logic       ad_oe,
	output logic            addr_strobe_in,
	output logic            data_strobe_in,
	output logic            read_write_in,
	output logic            chip_enable_n_in,
	output logic [7:0]      ad_in
);
	logic [7:0] cpu_ad;

	// Wire level: the block drives while enabled, otherwise the processor
	assign ad_in = ad_oe ? ad_out : cpu_ad;

	initial begin
		addr_strobe_in = 1'b0;
		data_strobe_in = 1'b0;
		read_write_in = 1'b1;
		chip_enable_n_in = 1'b1;
		cpu_ad = 8'h00;
	end

	task automatic hold(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : hold

	// One bus cycle; each pin level within it lasts three clocks or more so the
	// two-flop synchronisers surely see it. Released lines get inverted
	// so a stale value can never pass for read data.
	task automatic cycle(input logic [5:0] addr, input logic rd, input logic ce,
		input logic [7:0] wdata, output logic [7:0] rdata, output logic oe_seen);
		@(negedge clk_sys);
		chip_enable_n_in = ~ce;
		cpu_ad = {2'h0, addr};
		addr_strobe_in = 1'b1;
		hold(3);
		addr_strobe_in = 1'b0;
		hold(3);
		read_write_in = rd;
		cpu_ad = rd ? ~cpu_ad : wdata;
		data_strobe_in = 1'b1;
		hold(5);
		rdata = ad_in;
		oe_seen = ad_oe;
		data_strobe_in = 1'b0;
		hold(3);
		chip_enable_n_in = 1'b1;
		read_write_in = 1'b1;
		cpu_ad = ~cpu_ad;
	endtask : cycle
endmodule : rtccs_cpu_model

// >>> tb/testbench.sv
// Self-checking bench for the clock control and status registers.
// Assumes the processor model in rtccs_cpu_model and a 10 MHz clock.
`timescale 1ns/1ns
module testbench;
	logic       clk_sys;
	logic       sys_rst;
	logic       reset_in_n;
	logic       power_sense_in;
	logic       time_base_in;
	logic       update_advance;
	logic [7:0] tbyte;
	logic [7:0] ad_in;
	logic [7:0] ad_out;
	logic       ad_oe;
	logic       as_pin;
	logic       ds_pin;
	logic       rw_pin;
	logic       ce_n_pin;
	logic       irq_n_out;
	logic       irq_oe;
	logic       square_wave_out;
	logic       binary_format_select;
	logic       hour24_select;
	logic       summer_time_enable;
	int         fail_count = 0;
	int         comparisons = 0;

	rtccs_regs #(.UC_SLOW_CYCLES(20)) dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
		.reset_in_n(reset_in_n), .power_sense_in(power_sense_in),
		.time_base_in(time_base_in), .addr_strobe_in(as_pin), .data_strobe_in(ds_pin),
		.read_write_in(rw_pin), .chip_enable_n_in(ce_n_pin), .ad_in(ad_in),
		.ad_out(ad_out), .ad_oe(ad_oe), .irq_n_out(irq_n_out), .irq_oe(irq_oe),
		.square_wave_out(square_wave_out), .time_seconds(tbyte), .time_minutes(tbyte),
		.time_hours(tbyte), .alarm_seconds(~tbyte), .alarm_minutes(~tbyte),
		.alarm_hours(~tbyte), .update_advance(update_advance),
		.binary_format_select(binary_format_select), .hour24_select(hour24_select),
		.summer_time_enable(summer_time_enable));

	rtccs_cpu_model cpu (.clk_sys(clk_sys), .ad_out(ad_out), .ad_oe(ad_oe),
		.addr_strobe_in(as_pin), .data_strobe_in(ds_pin), .read_write_in(rw_pin),
		.chip_enable_n_in(ce_n_pin), .ad_in(ad_in));

	// ----------------------------------------------------------------
	// Clock and time base
	// ----------------------------------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end

	// Time base at half the clock: each level lasts a whole cycle for the
	// sampler, and one second of the slowest chain still fits in the run
	always @(negedge clk_sys) begin
		time_base_in <= ~time_base_in;
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] x;
		logic       o;
		cpu.cycle(a, 1'b0, 1'b1, d, x, o);
	endtask : wr

	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		logic [7:0] x;
		logic       o;
		cpu.cycle(a, 1'b1, 1'b1, 8'h00, x, o);
		check(x, exp);
	endtask : rd

	// Window longer than one periodic tap period at rate 1
	task automatic watch(output int hi, output int irq);
		hi = 0;
		irq = 0;
		repeat (1100) begin
			@(negedge clk_sys);
			hi += int'(square_wave_out === 1'b1);
			irq += int'(irq_oe === 1'b1);
		end
	endtask : watch

	task automatic tally_and_finish;
		if (fail_count == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : tally_and_finish

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_reset;
		logic [7:0] x;
		logic       o;
		rd(6'h0a, 8'h00);
		rd(6'h0b, 8'h00);
		rd(6'h0c, 8'h00);
		cpu.cycle(6'h0b, 1'b1, 1'b0, 8'h00, x, o);
		check({7'h0, o}, 8'h00);
		check({7'h0, irq_oe}, 8'h00);
	endtask : t_reset

	task automatic t_periodic;
		int hi;
		int ir;
		wr(6'h0a, 8'h21);
		rd(6'h0a, 8'h21);
		wr(6'h0b, 8'h48);
		watch(hi, ir);
		check({7'h0, hi > 0 && hi < 1100}, 8'h01);
		check({7'h0, ir > 0}, 8'h01);
		rd(6'h0c, 8'hc0);
		check({7'h0, irq_oe}, 8'h00);
		wr(6'h0b, 8'h08);
		watch(hi, ir);
		check({7'h0, ir != 0}, 8'h00);
		rd(6'h0c, 8'h40);
		wr(6'h0b, 8'h00);
		watch(hi, ir);
		check({7'h0, hi != 0}, 8'h00);
	endtask : t_periodic

	// Rate off first; the tap flag left by the last window must survive a write
	task automatic t_status;
		wr(6'h0a, 8'h20);
		wr(6'h0c, 8'hff);
		rd(6'h0c, 8'h40);
		wr(6'h0d, 8'hff);
		rd(6'h0c, 8'h00);
		rd(6'h0d, 8'h00);
		power_sense_in = 1'b1;
		cpu.hold(4);
		rd(6'h0d, 8'h00);
		rd(6'h0d, 8'h80);
		power_sense_in = 1'b0;
		cpu.hold(4);
		rd(6'h0d, 8'h00);
	endtask : t_status

	task automatic t_pin_reset;
		wr(6'h0b, 8'h7f);
		check({5'h0, binary_format_select, hour24_select, summer_time_enable}, 8'h07);
		reset_in_n = 1'b0;
		cpu.hold(5);
		reset_in_n = 1'b1;
		cpu.hold(4);
		rd(6'h0b, 8'h07);
		rd(6'h0a, 8'h20);
		wr(6'h0b, 8'h10);
		wr(6'h0b, 8'h90); // Set-hold and update-end enable in one write
		rd(6'h0b, 8'h80);
		rd(6'h0a, 8'h20);
		wr(6'h0b, 8'h00);
	endtask : t_pin_reset

	// Divider held, then released: a second is 32768 ticks of two clocks each,
	// so the lead-in flag stands about 16 clocks ahead of the boundary
	task automatic t_update;
		int n;
		wr(6'h0b, 8'h10);
		wr(6'h0a, 8'h60);
		rd(6'h0a, 8'h60);
		wr(6'h0a, 8'h20);
		cpu.hold(65000);
		rd(6'h0a, 8'h20);
		cpu.hold(505);
		rd(6'h0a, 8'ha0);
		n = 0;
		while (update_advance !== 1'b1 && n < 64) begin
			@(negedge clk_sys);
			n++;
		end
		check({7'h0, n >= 17 && n <= 23}, 8'h01);
		@(negedge clk_sys);
		check({6'h0, irq_oe, irq_n_out}, 8'h02);
		rd(6'h0c, 8'hb0);
		check({7'h0, irq_oe}, 8'h00);
	endtask : t_update

	// ----------------------------------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------------------------------
	initial begin
		sys_rst = 1'b1;
		reset_in_n = 1'b1;
		power_sense_in = 1'b0;
		time_base_in = 1'b0;
		tbyte = 8'h00;
		repeat (12) @(negedge clk_sys);
		sys_rst = 1'b0;
		repeat (3) @(negedge clk_sys);
		t_reset();
		t_periodic();
		t_status();
		t_pin_reset();
		t_update();
		tally_and_finish();
	end

	// The run needs about seven million ns, mostly the one-second wait
	initial begin
		#9000000;
		fail_count++;
		tally_and_finish();
	end
endmodule : testbench
